// ---- include/aos_pkg.sv ----
// Shared constants, register map and carrier types for the accumulator overflow status block
package aos_pkg;
   // Samples per waveform and accumulated output word width
   localparam int RECORD_LEN = 64;
   localparam int IDX_W = 6;
   localparam int SAMPLE_W = 16;
   localparam int ACC_W = 32;
   localparam int COUNT_W = 16;
   localparam int SEQ_W = 32;
   // Record on the link: three metadata words, then the samples
   localparam int META_WORDS = 3;
   localparam int WORD_IDX_W = 7;
   localparam logic [WORD_IDX_W-1:0] LAST_WORD = 7'h42;
   localparam logic [WORD_IDX_W-1:0] META_LAST = 7'h02;

   // Register byte offsets
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_ACCUM_COUNT = 8'h04;
   localparam logic [7:0] REG_IRQ_STATUS = 8'h08;
   localparam logic [7:0] REG_IRQ_MASK = 8'h0C;
   localparam logic [7:0] REG_SEQ = 8'h10;
   localparam logic [7:0] REG_STATE = 8'h14;
   localparam logic [COUNT_W-1:0] ACCUM_COUNT_RESET = 16'h0001;

   // Status flag positions in the record metadata block
   localparam int FLAG_DROPPED = 0;
   localparam int FLAG_CAUSE = 1;
   localparam int FLAG_PARTIAL = 2;
   localparam int FLAG_SATURATED = 3;

   // Interrupt event positions
   localparam int EVT_SENT = 0;
   localparam int EVT_DROP = 1;
   localparam int EVT_PARTIAL = 2;
   localparam int EVT_SAT = 3;

   typedef enum logic [1:0] {
      OUT_IDLE = 2'b00,
      OUT_BUF  = 2'b01,
      OUT_META = 2'b10,
      OUT_DATA = 2'b11
   } aos_out_state_t;

   typedef struct packed {
      logic [SEQ_W-1:0] seq;
      logic [COUNT_W-1:0] count;
      logic [3:0] flags;
   } aos_meta_t;

   typedef struct packed {
      logic valid;
      logic [SAMPLE_W-1:0] data;
   } aos_sample_t;

   typedef struct packed {
      logic valid;
      logic last;
      logic [ACC_W-1:0] data;
   } aos_link_t;
endpackage : aos_pkg

// ---- design/aos_accumulator_overflow_status.sv ----
// Waveform accumulator with overflow handling and per-record status flags
//
// How it works
// - A record held for transfer stays untouched; only new waveforms get dropped.
// - Dropped waveforms still count in their trigger slot, so records stay aligned to the grid.
// - Every overflow shows up in the status flags of a record's metadata.
// - Flag bit 1 tells queue exhaustion (1) from a link stall (0).
// - Short records report their real summed count and set flag bit 2.
// - Sequence count advances per started slot; dropped records set flag bit 0.
// - An empty buffer queue stalls output, and persisting stall drops input.
// - Each accumulated output sample is one 32-bit word.
// - Flag bit 3 marks records where any sample saturated.
// - Grid slots span the configured number of consecutive triggers.
//
// Implementation choices: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
module aos_accumulator_overflow_status (
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic [7:0] regAddr,
   input wire logic [31:0] regWrData,
   input wire logic regWrite,
   input wire logic regRead,
   output logic [31:0] regRdData,
   input wire logic trigger,
   input wire aos_pkg::aos_sample_t sampleIn,
   output aos_pkg::aos_link_t linkOut,
   input wire logic linkReady,
   input wire logic bufferAvail,
   output logic bufferTake,
   output logic irq
);
   import aos_pkg::*;

   // Two banks: one accumulates while the other drains to the link
   logic [ACC_W-1:0] mem [2][RECORD_LEN];

   logic enable_q;
   logic [COUNT_W-1:0] numAccum_q;
   logic [3:0] irqStatus_q;
   logic [3:0] irqMask_q;
   logic [SEQ_W-1:0] slotSeq_q;
   logic [COUNT_W-1:0] trigCnt_q;
   logic [COUNT_W-1:0] accCount_q;
   logic accSat_q;
   logic accBank_q;
   logic wfActive_q;
   logic wfWrite_q;
   logic [IDX_W-1:0] sampIdx_q;
   logic recReady_q;
   aos_meta_t heldMeta_q;
   aos_meta_t outMeta_q;
   logic dropPending_q;
   logic ovfCause_q;
   aos_out_state_t outState_q;
   logic [WORD_IDX_W-1:0] wordIdx_q;
   logic [ACC_W-1:0] linkData_q;

   logic trigTaken;
   logic sampleTake;
   logic wfDone;
   logic slotEnd;
   logic handover;
   logic overflowEvt;
   logic linkAccept;
   logic bufGrant;
   logic [COUNT_W-1:0] accCountNext;
   logic [ACC_W-1:0] satSum;
   logic satHit;
   logic [ACC_W-1:0] sampleExt;
   logic [WORD_IDX_W-1:0] fetchIdx;
   logic [WORD_IDX_W-1:0] memIdxWide;
   logic [ACC_W-1:0] fetchWord;
   logic [3:0] recFlags;
   logic [3:0] events;

   // Saturating add of a signed sample into a signed 32-bit sum
   function automatic logic [ACC_W:0] sat_add(input logic [ACC_W-1:0] acc,
                                              input logic [SAMPLE_W-1:0] smp);
      logic [ACC_W:0] wide;
      logic [ACC_W:0] res;
      wide = {acc[ACC_W-1], acc} + {{(ACC_W-SAMPLE_W+1){smp[SAMPLE_W-1]}}, smp};
      res = {1'b0, wide[ACC_W-1:0]};
      if (wide[ACC_W] != wide[ACC_W-1]) begin
         res = wide[ACC_W] ? {1'b1, 32'h80000000} : {1'b1, 32'h7FFFFFFF};
      end
      return res;
   endfunction : sat_add

   // A trigger opens a waveform only when none is running
   assign trigTaken = enable_q && trigger && !wfActive_q;
   assign sampleTake = wfActive_q && sampleIn.valid;
   assign wfDone = sampleTake && (sampIdx_q == IDX_W'(RECORD_LEN - 1));
   assign slotEnd = wfDone && (trigCnt_q + 16'h0001 >= numAccum_q);
   assign handover = recReady_q && (outState_q == OUT_IDLE);
   // A trigger that finds the bank still held is lost input
   assign overflowEvt = trigTaken && recReady_q;
   assign accCountNext = (wfWrite_q && wfDone) ? accCount_q + 16'h0001 : accCount_q;
   assign sampleExt = {{(ACC_W-SAMPLE_W){sampleIn.data[SAMPLE_W-1]}}, sampleIn.data};
   assign {satHit, satSum} = sat_add(mem[accBank_q][sampIdx_q], sampleIn.data);

   always_ff @(posedge clk_sys) begin
      if (wfWrite_q && sampleIn.valid) begin
         // First waveform of a bank overwrites, later ones sum
         mem[accBank_q][sampIdx_q] <= (accCount_q == 16'h0000) ? sampleExt : satSum;
      end
   end

   // Waveform capture; writes are off while the bank is held for transfer
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         wfActive_q <= 1'b0;
         wfWrite_q <= 1'b0;
         sampIdx_q <= '0;
      end else if (trigTaken) begin
         wfActive_q <= 1'b1;
         wfWrite_q <= !recReady_q;
         sampIdx_q <= '0;
      end else if (wfDone) begin
         wfActive_q <= 1'b0;
         wfWrite_q <= 1'b0;
         sampIdx_q <= '0;
      end else if (sampleTake) begin
         sampIdx_q <= sampIdx_q + 6'h01;
      end
   end

   // Grid: triggers count through slots whether captured or not
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         trigCnt_q <= '0;
         slotSeq_q <= '0;
      end else begin
         if (trigTaken && trigCnt_q == 16'h0000) begin
            slotSeq_q <= slotSeq_q + 32'h00000001;
         end
         if (slotEnd) begin
            trigCnt_q <= '0;
         end else if (wfDone) begin
            trigCnt_q <= trigCnt_q + 16'h0001;
         end
      end
   end

   // Per-bank count and saturation, restarted when the bank is closed
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         accCount_q <= '0;
         accSat_q <= 1'b0;
      end else if (slotEnd) begin
         accCount_q <= '0;
         accSat_q <= 1'b0;
      end else begin
         accCount_q <= accCountNext;
         if (wfWrite_q && sampleIn.valid && accCount_q != 16'h0000 && satHit) begin
            accSat_q <= 1'b1;
         end
      end
   end

   // Flags for the record closed at this slot end
   always_comb begin
      recFlags = 4'h0;
      recFlags[FLAG_DROPPED] = dropPending_q;
      recFlags[FLAG_PARTIAL] = accCountNext < numAccum_q;
      recFlags[FLAG_SATURATED] = accSat_q
         || (wfWrite_q && sampleIn.valid && accCount_q != 16'h0000 && satHit);
      // Cause only means something when data was actually lost
      recFlags[FLAG_CAUSE] = (recFlags[FLAG_DROPPED] || recFlags[FLAG_PARTIAL])
         && ovfCause_q;
   end

   // Closed slot: held for transfer, or counted as a dropped record if empty
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         recReady_q <= 1'b0;
         heldMeta_q <= '0;
         dropPending_q <= 1'b0;
      end else begin
         if (slotEnd && accCountNext != 16'h0000) begin
            recReady_q <= 1'b1;
            heldMeta_q.seq <= slotSeq_q;
            heldMeta_q.count <= accCountNext;
            heldMeta_q.flags <= recFlags;
            dropPending_q <= 1'b0;
         end else begin
            if (handover) begin
               recReady_q <= 1'b0;
            end
            if (slotEnd) begin
               dropPending_q <= 1'b1;
            end
         end
      end
   end

   // Where the stall sits when input is lost
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         ovfCause_q <= 1'b0;
      end else if (overflowEvt) begin
         ovfCause_q <= (outState_q == OUT_BUF);
      end
   end

   // Bank swap hands the held record to the output side
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         accBank_q <= 1'b0;
         outMeta_q <= '0;
      end else if (handover) begin
         accBank_q <= !accBank_q;
         outMeta_q <= heldMeta_q;
      end
   end

   // Output: wait for a free buffer, then metadata words, then samples
   assign bufGrant = (outState_q == OUT_BUF) && bufferAvail;
   assign bufferTake = bufGrant;
   assign linkAccept = linkOut.valid && linkReady;
   assign fetchIdx = (outState_q == OUT_BUF) ? '0 : wordIdx_q + 7'h01;
   assign memIdxWide = fetchIdx - 7'(META_WORDS);

   always_comb begin
      fetchWord = mem[!accBank_q][memIdxWide[IDX_W-1:0]];
      if (fetchIdx == 7'h00) begin
         fetchWord = outMeta_q.seq;
      end else if (fetchIdx == 7'h01) begin
         fetchWord = {16'h0000, outMeta_q.count};
      end else if (fetchIdx == META_LAST) begin
         fetchWord = {28'h0000000, outMeta_q.flags};
      end
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         outState_q <= OUT_IDLE;
         wordIdx_q <= '0;
         linkData_q <= '0;
      end else begin
         unique case (outState_q)
            OUT_IDLE: begin
               if (handover) begin
                  outState_q <= OUT_BUF;
               end
            end
            OUT_BUF: begin
               // Stalls here while the host leaves the queue empty
               if (bufGrant) begin
                  outState_q <= OUT_META;
                  wordIdx_q <= '0;
                  linkData_q <= fetchWord;
               end
            end
            OUT_META: begin
               if (linkAccept) begin
                  wordIdx_q <= fetchIdx;
                  linkData_q <= fetchWord;
                  if (wordIdx_q == META_LAST) begin
                     outState_q <= OUT_DATA;
                  end
               end
            end
            OUT_DATA: begin
               if (linkAccept) begin
                  if (wordIdx_q == LAST_WORD) begin
                     outState_q <= OUT_IDLE;
                  end else begin
                     wordIdx_q <= fetchIdx;
                     linkData_q <= fetchWord;
                  end
               end
            end
         endcase
      end
   end

   assign linkOut.valid = (outState_q == OUT_META) || (outState_q == OUT_DATA);
   assign linkOut.last = (outState_q == OUT_DATA) && (wordIdx_q == LAST_WORD);
   assign linkOut.data = linkData_q;

   // Interrupt events
   always_comb begin
      events = 4'h0;
      events[EVT_SENT] = linkAccept && linkOut.last;
      events[EVT_DROP] = slotEnd && accCountNext == 16'h0000;
      events[EVT_PARTIAL] = slotEnd && accCountNext != 16'h0000 && recFlags[FLAG_PARTIAL];
      events[EVT_SAT] = slotEnd && accCountNext != 16'h0000 && recFlags[FLAG_SATURATED];
   end

   // Control registers
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         enable_q <= 1'b0;
         numAccum_q <= ACCUM_COUNT_RESET;
         irqMask_q <= 4'h0;
      end else if (regWrite) begin
         if (regAddr == REG_CTRL) begin
            enable_q <= regWrData[0];
         end
         // Zero would make an empty grid slot, so it is held at one
         if (regAddr == REG_ACCUM_COUNT) begin
            numAccum_q <= (regWrData[15:0] == 16'h0000) ? ACCUM_COUNT_RESET : regWrData[15:0];
         end
         if (regAddr == REG_IRQ_MASK) begin
            irqMask_q <= regWrData[3:0];
         end
      end
   end

   // Sticky status, write one to clear; a new event wins over the clear
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         irqStatus_q <= 4'h0;
      end else if (regWrite && regAddr == REG_IRQ_STATUS) begin
         irqStatus_q <= (irqStatus_q & ~regWrData[3:0]) | events;
      end else begin
         irqStatus_q <= irqStatus_q | events;
      end
   end

   assign irq = |(irqStatus_q & irqMask_q);

   // Read data stands in the cycle after the strobe only
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         regRdData <= '0;
      end else if (regRead) begin
         unique case (regAddr)
            REG_CTRL: regRdData <= {31'h00000000, enable_q};
            REG_ACCUM_COUNT: regRdData <= {16'h0000, numAccum_q};
            REG_IRQ_STATUS: regRdData <= {28'h0000000, irqStatus_q};
            REG_IRQ_MASK: regRdData <= {28'h0000000, irqMask_q};
            REG_SEQ: regRdData <= slotSeq_q;
            REG_STATE: regRdData <= {27'h0000000, dropPending_q, wfActive_q, outState_q,
                                     recReady_q};
            default: regRdData <= '0;
         endcase
      end else begin
         regRdData <= '0;
      end
   end
endmodule : aos_accumulator_overflow_status

// ---- tb/aos_overflow_checker_asserts.sv ----
// Port checker for the overflow status block
`timescale 1ns/1ps
module aos_overflow_checker (
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic [7:0] regAddr,
   input wire logic [31:0] regWrData,
   input wire logic regWrite,
   input wire logic regRead,
   input wire logic [31:0] regRdData,
   input wire logic trigger,
   input wire aos_pkg::aos_sample_t sampleIn,
   input wire aos_pkg::aos_link_t linkOut,
   input wire logic linkReady,
   input wire logic bufferAvail,
   input wire logic bufferTake,
   input wire logic irq
);
   import aos_pkg::*;
   logic [6:0] wordIdx_q;
   default clocking @(posedge clk_sys);
   endclocking
   default disable iff (!reset_n);
   // Word position within the record now on the link
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         wordIdx_q <= 7'h00;
      end else if (linkOut.valid && linkReady) begin
         wordIdx_q <= linkOut.last ? 7'h00 : wordIdx_q + 7'h01;
      end
   end
   a_take_avail: assert property (bufferTake |-> bufferAvail && !linkOut.valid)
      else $error("buffer taken with none free");
   a_take_word: assert property (bufferTake |=> linkOut.valid && wordIdx_q == 7'h00)
      else $error("record did not start after buffer take");
   a_stall_hold: assert property (linkOut.valid && !linkReady
      |=> linkOut.valid && $stable(linkOut.data))
      else $error("held word changed during stall");
   a_last_word: assert property (linkOut.valid |-> linkOut.last == (wordIdx_q == LAST_WORD))
      else $error("last marker on wrong word");
   a_count_word: assert property (linkOut.valid && wordIdx_q == 7'h01
      |-> linkOut.data[31:16] == 16'h0000 && linkOut.data[15:0] != 16'h0000)
      else $error("summed count word malformed");
   a_flag_word: assert property (linkOut.valid && wordIdx_q == META_LAST
      |-> linkOut.data[31:4] == 28'h0
      && (!linkOut.data[1] || linkOut.data[0] || linkOut.data[2]))
      else $error("flag word malformed");
   a_read_idle: assert property (!regRead |=> regRdData == 32'h0)
      else $error("read data outside read slot");
   // Checked in the very next cycle: a following mask write may re-enable it after that
   a_mask_quiet: assert property (regWrite && regAddr == REG_IRQ_MASK && regWrData[3:0] == 4'h0
      |=> !irq)
      else $error("interrupt with all events masked");
endmodule : aos_overflow_checker
bind aos_accumulator_overflow_status aos_overflow_checker chk_i (.clk_sys(clk_sys),
   .reset_n(reset_n), .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite),
   .regRead(regRead), .regRdData(regRdData), .trigger(trigger), .sampleIn(sampleIn),
   .linkOut(linkOut), .linkReady(linkReady), .bufferAvail(bufferAvail),
   .bufferTake(bufferTake), .irq(irq));

// ---- tb/aos_host_model.sv ----
// Host side: free-buffer queue and record link sink
`timescale 1ns/1ps
module aos_host_model (
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire aos_pkg::aos_link_t linkOut,
   input wire logic bufferTake,
   input wire logic [7:0] gift,
   input wire logic stall,
   input wire logic fast,
   output logic linkReady,
   output logic bufferAvail
);
   import aos_pkg::*;
   int freeBufs;
   logic tog;
   logic [31:0] got[$];
   // Queue runs dry only when the bench stops handing buffers back
   assign bufferAvail = freeBufs > 0;
   assign linkReady = !stall && (fast || tog);
   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         freeBufs <= 0;
         tog <= 1'b0;
      end else begin
         freeBufs <= freeBufs + int'(gift) - int'(bufferTake);
         tog <= !tog;
         if (linkOut.valid && linkReady) got.push_back(linkOut.data);
      end
   end
endmodule : aos_host_model

// ---- tb/aos_accumulator_overflow_status_bench.sv ----
// Self-checking bench for the overflow status block
`timescale 1ns/1ps
module aos_accumulator_overflow_status_bench;
   import aos_pkg::*;
   logic clk_sys, reset_n, regWrite, regRead, trigger, linkReady, bufferAvail;
   logic bufferTake, irq, stall, fast;
   logic [7:0] regAddr, gift;
   logic [31:0] regWrData, regRdData;
   aos_sample_t sampleIn;
   aos_link_t linkOut;
   int fails, checks, seed, nAcc, cnt, sq, pos;
   int cyc = 0;
   int acc[64];
   logic [31:0] expQ[$];
   aos_accumulator_overflow_status dut (.clk_sys(clk_sys), .reset_n(reset_n),
      .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
      .regRdData(regRdData), .trigger(trigger), .sampleIn(sampleIn), .linkOut(linkOut),
      .linkReady(linkReady), .bufferAvail(bufferAvail), .bufferTake(bufferTake), .irq(irq));
   aos_host_model host (.clk_sys(clk_sys), .reset_n(reset_n), .linkOut(linkOut),
      .bufferTake(bufferTake), .gift(gift), .stall(stall), .fast(fast),
      .linkReady(linkReady), .bufferAvail(bufferAvail));
   initial begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fails++;
         end_sim();
      end
   end
   task end_sim;
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : end_sim
   task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      checks++;
      if (s !== e) begin
         fails++;
         $display("BAD %s exp %h got %h", nm, e, s);
      end
   endtask : chk
   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      regAddr <= a;
      regWrData <= d;
      regWrite <= 1'b1;
      @(posedge clk_sys);
      regWrite <= 1'b0;
   endtask : wr
   task rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge clk_sys);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge clk_sys);
      regRead <= 1'b0;
      #1;
      chk("reg", regRdData, e);
   endtask : rd
   task give(input logic [7:0] n);
      @(posedge clk_sys);
      gift <= n;
      @(posedge clk_sys);
      gift <= 8'h00;
   endtask : give
   // One waveform; the model sums it only when the block should capture it
   task wave(input bit cap);
      shortint v;
      @(posedge clk_sys);
      trigger <= 1'b1;
      for (int i = 0; i < 64; i++) begin
         @(posedge clk_sys);
         trigger <= 1'b0;
         v = shortint'($random(seed));
         sampleIn <= '{1'b1, v};
         if (cap) acc[i] += v;
      end
      @(posedge clk_sys);
      sampleIn.valid <= 1'b0;
      cnt += cap;
   endtask : wave
   // Slot end: sequence always advances, a record is expected only if kept
   task close(input int fl, input bit keep);
      sq++;
      if (keep) begin
         expQ.push_back(sq);
         expQ.push_back(cnt);
         expQ.push_back(fl | ((cnt < nAcc) ? 4 : 0));
         for (int i = 0; i < 64; i++) expQ.push_back(acc[i]);
      end
      for (int i = 0; i < 64; i++) acc[i] = 0;
      cnt = 0;
   endtask : close
   task slot(input int fl, input bit keep);
      for (int k = 0; k < nAcc; k++) wave(keep);
      close(fl, keep);
   endtask : slot
   task rx;
      int t;
      for (t = 0; t < 3000 && host.got.size() < expQ.size(); t++) @(posedge clk_sys);
      chk("words", 32'(host.got.size()), 32'(expQ.size()));
      while (pos < expQ.size()) begin
         chk("word", host.got[pos], expQ[pos]);
         pos++;
      end
   endtask : rx
   task irqChk(input string nm, input logic [31:0] st);
      rd(REG_IRQ_STATUS, st);
      chk("irq", irq, 32'h1);
      wr(REG_IRQ_MASK, 32'h0);
      rd(REG_SEQ, sq);
      chk("irq", irq, 32'h0);
      wr(REG_IRQ_MASK, 32'hF);
      wr(REG_IRQ_STATUS, st);
      rd(REG_IRQ_STATUS, 32'h0);
      chk("irq", irq, 32'h0);
      $display("test %s done", nm);
   endtask : irqChk
   initial begin
      seed = 56;
      {regAddr, regWrData, regWrite, regRead, trigger, gift, stall, reset_n} = '0;
      sampleIn = '0;
      fast = 1'b0;
      nAcc = 2;
      repeat (2) @(posedge clk_sys);
      reset_n <= 1'b1;
      rd(REG_ACCUM_COUNT, 32'h1);
      rd(REG_CTRL, 32'h0);
      wr(REG_ACCUM_COUNT, 32'h0);
      rd(REG_ACCUM_COUNT, 32'h1);
      rd(8'h20, 32'h0);
      wr(REG_ACCUM_COUNT, 32'h2);
      wr(REG_IRQ_MASK, 32'hF);
      wr(REG_CTRL, 32'h1);
      give(8'h02);
      slot(0, 1);
      slot(0, 1);
      rx();
      irqChk("clean", 32'h1);
      // Buffer queue dry: two records wait, two slots are lost whole
      slot(0, 1);
      slot(0, 1);
      slot(0, 0);
      slot(0, 0);
      // Output waits for a buffer, one record held, drop pending
      rd(REG_STATE, 32'h13);
      give(8'h03);
      rx();
      slot(3, 1);
      rx();
      irqChk("queue", 32'h3);
      // Link stall: first waveform of a slot lost, record comes out short
      give(8'h05);
      stall <= 1'b1;
      slot(0, 1);
      slot(0, 1);
      wave(0);
      stall <= 1'b0;
      fast <= 1'b1;
      rx();
      wave(1);
      close(0, 1);
      rx();
      irqChk("stall", 32'h5);
      end_sim();
   end
endmodule : aos_accumulator_overflow_status_bench
